/* File: adc_seq_map.vh */
// Register map, field positions and timing constants of the converter block
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define ADDR_W 16
`define OFS_RESULT_BASE 16'h12A0
`define OFS_RESULT_LAST 16'h12AF
`define OFS_CH7_UPPER 16'h12AF
`define OFS_MODE_A 16'h12B0
`define OFS_MODE_B 16'h12B1
`define OFS_IRQ_STATUS 16'h12B2
`define OFS_IRQ_MASK 16'h12B3
`define MA_END_FLAG 7
`define MA_BUSY_FLAG 6
`define MA_IRQ_FOURTH 5
`define MA_CONTINUOUS 4
`define MA_MULTI 3
`define MA_START 0
`define MB_LADDER_ON 7
`define MB_EXT_TRIG_EN 5
`define MB_INPUT_LO 0
`define MODE_A_RESET 8'h00
`define MODE_B_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define LOWER_ONES 8'h3E
`define CONV_STATES 84
`define RESULT_BITS 10
`endif

/* File: adc_seq_sva.sv */
// Port checks for the converter control block
`include "adc_seq_map.vh"
module adc_seq_sva (
  input wire sys_clk,
  input wire sys_rst,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire ladder_switch_closed,
  input wire [2:0] analog_mux_sel,
  input wire conversion_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] mask_copy;
  wire wr_b = wr_en && addr == `OFS_MODE_B;
  always @(posedge sys_clk)
    if (sys_rst)
      mask_copy <= 8'h00;
    else if (wr_en && addr == `OFS_IRQ_MASK)
      mask_copy <= wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ladder_follow_a: assert property (
    wr_b |=> ladder_switch_closed == $past(wdata[7])) else $error("ladder");
  ladder_hold_a: assert property (
    !wr_b |=> $stable(ladder_switch_closed)) else $error("ladder moved");
  lower_ones_a: assert property (
    rd_en && addr[15:4] == 12'h12A && !addr[0] |=> rdata[5:1] == 5'h1F)
    else $error("lower bits");
  reset_sel_a: assert property (disable iff (1'b0)
    sys_rst |=> analog_mux_sel == 3'h0) else $error("reset channel");
  irq_mask_a: assert property (
    mask_copy == 8'h00 |-> !conversion_done_irq) else $error("masked irq");
  start_zero_a: assert property (
    rd_en && addr == `OFS_MODE_A |=> !rdata[0]) else $error("start bit");
  rd_idle_a: assert property (
    !rd_en |=> rdata == 8'h00) else $error("idle data");
  unmapped_zero_a: assert property (
    rd_en && addr < `OFS_RESULT_BASE |=> rdata == 8'h00) else $error("hole");
endmodule
bind adc_sequencer_control adc_seq_sva chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .ladder_switch_closed(ladder_switch_closed),
  .analog_mux_sel(analog_mux_sel), .conversion_done_irq(conversion_done_irq));

/* File: adc_sequencer_control.v */
// Converter control: modes, channel scan, result registers and interrupt
// Overview of operation
// - Lower result reads bits 5..1 as ones
// - Stored flag set on write, cleared on read
// - Ten-bit result split upper eight, lower two
// - Ladder bit zero opens reference switch
// - Fixed mode: code n selects input n; a start in the write leaving scan mode takes input 0
// - Scan mode: inputs 0 through n ascending; a start in the write entering scan mode converts input n alone first
// - Reset gives fixed mode, input zero
// - Start by software bit or trigger edge
// - Busy flag set throughout conversion
// - Repeat and scan bits choose four modes
// - Completion raises interrupt and end flag
// - Fixed single: once, end, unbusy, interrupt
// - Scan single: after whole scan, same actions
// - One channel takes 84 clock states
// - Fixed repeat may interrupt every fourth
// - Scan repeat interrupts per scan, stays busy
// - Any result read clears end flag
//
// The address-and-strobe port was left to the implementer.
`include "adc_seq_map.vh"
module adc_sequencer_control #(
  parameter CONV_CYCLES = `CONV_STATES,
  parameter NUM_CH = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire ext_trigger_pin,
  input wire compare_high,
  output wire [9:0] dac_trial,
  output wire [2:0] analog_mux_sel,
  output wire ladder_switch_closed,
  output wire conversion_done_irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_NEXT = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  reg end_flag;
  reg irq_fourth;
  reg continuous;
  reg multi;
  reg ladder_on;
  reg trig_en;
  reg [2:0] input_sel;
  reg [2:0] channel;
  reg [1:0] rep_count;
  reg trig_prev;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [9:0] result_mem [0:NUM_CH-1];
  reg [NUM_CH-1:0] stored;
  reg core_start;
  wire core_done;
  wire [9:0] core_result;
  wire busy = (state != ST_IDLE);
  // Result window covers eight channels, two bytes each
  function is_result;
    input [`ADDR_W-1:0] a;
    begin
      is_result = (a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST);
    end
  endfunction
  wire [`ADDR_W-1:0] rel = addr - `OFS_RESULT_BASE;
  wire [2:0] rd_ch = rel[3:1];
  wire rd_upper = rel[0];
  wire rd_result = rd_en && is_result(addr);
  wire wr_a = wr_en && (addr == `OFS_MODE_A);
  wire sw_start = wr_a && wdata[`MA_START];
  wire trig_fall = trig_en && trig_prev && !ext_trigger_pin;
  wire go = sw_start || trig_fall;
  // Fixed mode converts input_sel, or input 0 if started by the write leaving scan; scan ends at input_sel
  wire last_ch = multi ? (channel == input_sel) : 1'b1;
  wire repeat_now = continuous;
  wire fixed_rep = continuous && !multi;
  wire fourth_hit = !irq_fourth || (rep_count == 2'b11);
  wire done_event = core_done && last_ch && (!fixed_rep || fourth_hit);
  assign ladder_switch_closed = ladder_on;
  assign analog_mux_sel = channel;
  assign conversion_done_irq = |(irq_status & irq_mask);
  sar_core #(
    .CONV_CYCLES(CONV_CYCLES),
    .RES_W(`RESULT_BITS)
  ) u_core (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(core_start),
    .compare_high(compare_high),
    .trial(dac_trial),
    .done(core_done),
    .result(core_result)
  );
  always @*
  begin
    next_state = state;
    core_start = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (go)
        begin
          next_state = ST_CONV;
          core_start = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (core_done)
        begin
          if (!last_ch || repeat_now)
            next_state = ST_NEXT;
          else
            next_state = ST_IDLE;
        end
      end
      ST_NEXT:
      begin
        next_state = ST_CONV;
        core_start = 1'b1;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end
  // Channel stepping and repeat counting
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      channel <= 3'b000;
      rep_count <= 2'b00;
      trig_prev <= 1'b1;
    end
    else
    begin
      trig_prev <= ext_trigger_pin;
      if (state == ST_IDLE && go)
      begin
        channel <= multi ? 3'b000 : input_sel;
        rep_count <= 2'b00;
      end
      else if (core_done)
      begin
        if (multi)
          channel <= last_ch ? 3'b000 : channel + 3'b001;
        if (fixed_rep)
          rep_count <= rep_count + 2'b01;
      end
    end
  end
  // Control registers
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irq_fourth <= 1'b0;
      continuous <= 1'b0;
      multi <= 1'b0;
      ladder_on <= 1'b0;
      trig_en <= 1'b0;
      input_sel <= 3'b000;
      irq_mask <= `IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_a)
      begin
        irq_fourth <= wdata[`MA_IRQ_FOURTH];
        continuous <= wdata[`MA_CONTINUOUS];
        multi <= wdata[`MA_MULTI];
      end
      if (wr_en && addr == `OFS_MODE_B)
      begin
        ladder_on <= wdata[`MB_LADDER_ON];
        trig_en <= wdata[`MB_EXT_TRIG_EN];
        input_sel <= wdata[`MB_INPUT_LO+2:`MB_INPUT_LO];
      end
      if (wr_en && addr == `OFS_IRQ_MASK)
        irq_mask <= wdata;
    end
  end
  // End flag: a completion in the clearing cycle wins
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      end_flag <= 1'b0;
    else if (done_event)
      end_flag <= 1'b1;
    else if (rd_result)
      end_flag <= 1'b0;
  end
  // Interrupt status: read clears, new event wins
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      irq_status <= 8'h00;
    else if (done_event)
      irq_status <= 8'h01;
    else if (rd_en && addr == `OFS_IRQ_STATUS)
      irq_status <= 8'h00;
  end
  // Results, one entry per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : g_ch
      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          stored[g] <= 1'b0;
          result_mem[g] <= 10'h000;
        end
        else if (core_done && channel == g)
        begin
          result_mem[g] <= core_result;
          stored[g] <= 1'b1;
        end
        else if (rd_result && rd_ch == g)
          stored[g] <= 1'b0;
      end
    end
  endgenerate
  // Read data, one cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      if (is_result(addr))
      begin
        if (rd_upper)
          rdata <= result_mem[rd_ch][9:2];
        else
          rdata <= {result_mem[rd_ch][1:0], 5'h1F, stored[rd_ch]};
      end
      else if (addr == `OFS_MODE_A)
        rdata <= {end_flag, busy, irq_fourth, continuous, multi, 3'b000};
      else if (addr == `OFS_MODE_B)
        rdata <= {ladder_on, 1'b0, trig_en, 2'b00, input_sel};
      else if (addr == `OFS_IRQ_STATUS)
        rdata <= irq_status;
      else if (addr == `OFS_IRQ_MASK)
        rdata <= irq_mask;
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end
  // Software must allow 3 us ladder settle before starting.
endmodule

/* File: sar_core.v */
// Successive-approximation stepping core: one channel per start pulse
`include "adc_seq_map.vh"
module sar_core #(
  parameter CONV_CYCLES = `CONV_STATES,
  parameter RES_W = `RESULT_BITS
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire start,
  input wire compare_high,
  output reg [RES_W-1:0] trial,
  output reg done,
  output reg [RES_W-1:0] result
);
  localparam CNT_W = 7;
  localparam [CNT_W-1:0] LAST = CONV_CYCLES - 1;
  localparam [CNT_W-1:0] SETTLE = CONV_CYCLES - 1 - RES_W;
  reg [CNT_W-1:0] count;
  reg running;
  reg [RES_W-1:0] bit_mask;
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      count <= {CNT_W{1'b0}};
      running <= 1'b0;
      trial <= {RES_W{1'b0}};
      bit_mask <= {RES_W{1'b0}};
      done <= 1'b0;
      result <= {RES_W{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (start && !running)
      begin
        running <= 1'b1;
        count <= {CNT_W{1'b0}};
        bit_mask <= {1'b1, {(RES_W-1){1'b0}}};
        trial <= {1'b1, {(RES_W-1){1'b0}}};
      end
      else if (running)
      begin
        count <= count + 1'b1;
        // One decision per cycle once the sample has settled
        if (count >= SETTLE && bit_mask != {RES_W{1'b0}})
        begin
          if (!compare_high)
            trial <= (trial & ~bit_mask) | (bit_mask >> 1);
          else
            trial <= trial | (bit_mask >> 1);
          bit_mask <= bit_mask >> 1;
        end
        if (count == LAST)
        begin
          running <= 1'b0;
          done <= 1'b1;
          result <= trial;
        end
      end
    end
  end
endmodule

/* File: test_adc_sequencer_control.sv */
// Register-level tests of the converter control block
`include "adc_seq_map.vh"
module test_adc_sequencer_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam CC = 20;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg ext_trigger_pin = 1'b1;
  reg [9:0] level = 10'h2B7;
  wire [7:0] rdata;
  wire [9:0] dac_trial;
  wire [2:0] analog_mux_sel;
  wire ladder_switch_closed;
  wire conversion_done_irq;
  // Input sits half a step above level
  wire compare_high = level >= dac_trial;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  reg [7:0] d;
  always #4 sys_clk = ~sys_clk;
  adc_sequencer_control #(.CONV_CYCLES(CC)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ext_trigger_pin(ext_trigger_pin),
    .compare_high(compare_high), .dac_trial(dac_trial),
    .analog_mux_sel(analog_mux_sel),
    .ladder_switch_closed(ladder_switch_closed),
    .conversion_done_irq(conversion_done_irq));
  task wr(input [15:0] a, input [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input [15:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wirq;
    n = 0;
    while (conversion_done_irq !== 1'b1 && n < 1000)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`OFS_MODE_A);
    chk(d, 8'h00);
    rd(`OFS_MODE_B);
    chk(d, 8'h00);
    rd(16'h0000);
    chk(d, 8'h00);
    wr(`OFS_MODE_B, 8'h80);
    chk(ladder_switch_closed, 1);
    wr(`OFS_MODE_B, 8'h00);
    chk(ladder_switch_closed, 0);
    wr(`OFS_MODE_B, 8'h85);
    repeat (375) @(posedge sys_clk);
    $display("reset and ladder end");
    wr(`OFS_IRQ_MASK, 8'h01);
    wr(`OFS_MODE_A, 8'h01);
    rd(`OFS_MODE_A);
    chk(d & 8'hC1, 8'h40);
    chk(analog_mux_sel, 5);
    wirq;
    chk(n >= CC - 6 && n <= CC + 2, 1);
    rd(`OFS_IRQ_STATUS);
    chk(d, 8'h01);
    chk(conversion_done_irq, 0);
    rd(`OFS_MODE_A);
    chk(d & 8'hC0, 8'h80);
    rd(16'h12AA);
    chk(d, {level[1:0], 6'h3F});
    rd(`OFS_MODE_A);
    chk(d & 8'h80, 8'h00);
    rd(16'h12AB);
    chk(d, level[9:2]);
    rd(16'h12AA);
    chk(d, {level[1:0], 6'h3E});
    $display("fixed single end");
    level <= 10'h0D4;
    wr(`OFS_MODE_B, 8'hA2);
    wr(`OFS_MODE_A, 8'h08);
    ext_trigger_pin <= 1'b0;
    wirq;
    ext_trigger_pin <= 1'b1;
    chk(n > 2 * CC && n < 1000, 1);
    rd(`OFS_IRQ_STATUS);
    for (int c = 0; c < 4; c++)
    begin
      rd(16'h12A0 + 2 * c);
      chk(d & 8'h3F, c < 3 ? 8'h3F : 8'h3E);
    end
    rd(16'h12A5);
    chk(d, level[9:2]);
    $display("scan single end");
    wr(`OFS_MODE_A, 8'h19);
    wirq;
    rd(`OFS_IRQ_STATUS);
    rd(`OFS_MODE_A);
    chk(d & 8'hC0, 8'hC0);
    wr(`OFS_MODE_A, 8'h08);
    repeat (4 * CC) @(posedge sys_clk);
    rd(`OFS_MODE_A);
    chk(d & 8'h40, 8'h00);
    $display("scan repeat end");
    // Fixed repeat on input 0 (the start write still sees scan mode), interrupt only after the fourth result
    rd(`OFS_IRQ_STATUS);
    wr(`OFS_MODE_A, 8'h31);
    wirq;
    chk(n > 3 * CC && n < 5 * CC, 1);
    wr(`OFS_MODE_A, 8'h00);
    repeat (2 * CC) @(posedge sys_clk);
    rd(`OFS_MODE_A);
    chk(d & 8'h40, 8'h00);
    $display("fixed repeat end");
    end_of_test;
  end
endmodule
